// File: ricd_pkg.sv
// constants, types and register map of the remote input command decoder
// assumes a 250 MHz core clock and an apb slave port with 32-bit data
package ricd_pkg;

  localparam int NUM_INPUTS = 24;

  // register byte offsets
  localparam logic [11:0] CTRL_OFS   = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [11:0] LEVEL_OFS  = 12'h008;
  localparam logic [11:0] STATE_OFS  = 12'h00C;
  localparam logic [11:0] CFG_OFS    = 12'h040;

  // ctrl bits
  localparam int CTRL_COMMIT_BIT  = 0;
  localparam int CTRL_DISCARD_BIT = 1;
  // state bits
  localparam int STATE_RF_BIT     = 0;
  localparam int STATE_EXC_B_BIT  = 1;
  localparam int STATE_AUTO_BIT   = 2;
  localparam int STATE_PRESET_LSB = 4;
  // cfg field positions
  localparam int CFG_CHAN_LSB     = 0;
  localparam int CFG_MODE_LSB     = 4;
  localparam int CFG_PRESET_LSB   = 8;
  localparam int CFG_EXEMPT_BIT   = 12;

  // power step and repeat time
  localparam logic [15:0] POWER_STEP_W  = 16'h0064;
  localparam int          REPEAT_NS     = 500000000;
  localparam int          CLK_PERIOD_NS = 4;
  localparam int          REPEAT_CYC    = REPEAT_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    CH_NONE     = 3'h0,
    CH_RF       = 3'h1,
    CH_RESET    = 3'h2,
    CH_POWER    = 3'h3,
    CH_EXCITER  = 3'h4,
    CH_AUTO_CO  = 3'h5,
    CH_WATCHDOG = 3'h6,
    CH_PRESET   = 3'h7
  } ricd_chan_type;

  typedef enum logic [3:0] {
    MD_FALL_ON          = 4'h0,
    MD_RISE_ON          = 4'h1,
    MD_FALL_OFF         = 4'h2,
    MD_RISE_OFF         = 4'h3,
    MD_FALL_TOG         = 4'h4,
    MD_RISE_TOG         = 4'h5,
    MD_RISE_ON_FALL_OFF = 4'h6,
    MD_FALL_ON_RISE_OFF = 4'h7,
    MD_HIGH_INC         = 4'h8,
    MD_LOW_INC          = 4'h9,
    MD_HIGH_ON          = 4'hA,
    MD_LOW_ON           = 4'hB,
    MD_HIGH_DEC         = 4'hC,
    MD_LOW_DEC          = 4'hD
  } ricd_mode_type;

  typedef struct packed {
    logic          exempt;
    logic [3:0]    preset;
    ricd_mode_type mode;
    ricd_chan_type chan;
  } ricd_cfg_type;

  localparam ricd_cfg_type CFG_RESET_VAL = '{1'b0, 4'h0, MD_FALL_ON, CH_NONE};

  // factory configuration of the first seven inputs
  localparam int FACTORY_COUNT = 7;
  localparam ricd_cfg_type FACTORY_CFG [FACTORY_COUNT] = '{
    '{1'b0, 4'h0, MD_FALL_ON,  CH_RF},
    '{1'b0, 4'h0, MD_FALL_OFF, CH_RF},
    '{1'b0, 4'h0, MD_LOW_INC,  CH_POWER},
    '{1'b0, 4'h0, MD_LOW_DEC,  CH_POWER},
    '{1'b0, 4'h0, MD_FALL_OFF, CH_EXCITER},
    '{1'b0, 4'h0, MD_FALL_ON,  CH_EXCITER},
    '{1'b0, 4'h0, MD_FALL_TOG, CH_AUTO_CO}
  };

  typedef struct packed {
    logic       rf_on;
    logic       exciter_b;
    logic       auto_co;
    logic [3:0] preset;
  } ricd_state_type;

  localparam ricd_state_type STATE_RESET_VAL = '{1'b0, 1'b0, 1'b0, 4'h0};

endpackage

// File: ricd_top.sv
// remote input command decoder: 24 remote lines to transmitter commands
// assumes asynchronous inputs, resynchronised here, and an apb master on the core clock
`timescale 1ns/1ps
`default_nettype none

module ricd_top #(
  parameter int REPEAT_CYCLES = ricd_pkg::REPEAT_CYC
) (
  input  wire logic                             CORE_CLK_I,
  input  wire logic                             SYS_RST_I,
  input  wire logic [ricd_pkg::NUM_INPUTS-1:0]  REMOTE_IN_I,
  input  wire logic                             LOCAL_REMOTE_SEL_I,
  input  wire logic                             PSEL_I,
  input  wire logic                             PENABLE_I,
  input  wire logic                             PWRITE_I,
  input  wire logic [11:0]                      PADDR_I,
  input  wire logic [31:0]                      PWDATA_I,
  output logic      [31:0]                      PRDATA_O,
  output logic                                  PREADY_O,
  output logic                                  PSLVERR_O,
  output logic                                  RF_ON_REQ_O,
  output logic                                  RF_OFF_REQ_O,
  output logic                                  SYS_RESET_REQ_O,
  output logic                                  POWER_UP_O,
  output logic                                  POWER_DOWN_O,
  output logic      [15:0]                      POWER_STEP_W_O,
  output logic                                  EXCITER_B_O,
  output logic                                  AUTO_CO_EN_O,
  output logic                                  WDOG_RST_O,
  output logic                                  PRESET_LOAD_O,
  output logic      [3:0]                       PRESET_SEL_O
);

  localparam int N  = ricd_pkg::NUM_INPUTS;
  localparam int CW = $clog2(REPEAT_CYCLES + 1);

  logic [N-1:0]          sync_a;
  logic [N-1:0]          sync_b;
  logic [N-1:0]          prev;
  logic [N-1:0]          rise;
  logic [N-1:0]          fall;
  ricd_pkg::ricd_cfg_type edit_cfg [N];
  ricd_pkg::ricd_cfg_type act_cfg  [N];
  ricd_pkg::ricd_state_type state;
  logic [N-1:0]          ev_on;
  logic [N-1:0]          ev_off;
  logic [N-1:0]          ev_tog;
  logic [N-1:0]          hold;
  logic [N-1:0]          is_dec;
  logic [N-1:0]          rep_step;
  logic                  acc_wr;
  logic                  acc_rd;
  logic                  cfg_hit;
  logic [4:0]            cfg_idx;
  logic                  mapped;
  logic [31:0]           next_rdata;
  logic                  any_rf_on;
  logic                  any_rf_off;
  logic                  any_rf_tog;
  logic                  any_reset;
  logic                  any_up;
  logic                  any_down;
  logic                  any_exc_a;
  logic                  any_exc_b;
  logic                  any_exc_tog;
  logic                  any_auto_tog;
  logic                  any_wdog;
  logic                  any_preset;
  logic [3:0]            next_preset;

  // two-stage synchroniser and previous sample
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      sync_a <= '0;
      sync_b <= '0;
      prev   <= '0;
    end else begin
      sync_a <= REMOTE_IN_I;
      sync_b <= sync_a;
      prev   <= sync_b;
    end
  end

  assign rise = sync_b & ~prev;
  assign fall = ~sync_b & prev;

  // apb decode, zero wait states
  assign acc_wr  = PSEL_I & PENABLE_I & PWRITE_I;
  assign acc_rd  = PSEL_I & ~PENABLE_I & ~PWRITE_I;
  assign cfg_hit = (PADDR_I >= ricd_pkg::CFG_OFS) && (PADDR_I < ricd_pkg::CFG_OFS + 12'(4 * N))
                   && (PADDR_I[1:0] == 2'b00);
  assign cfg_idx = 5'((PADDR_I - ricd_pkg::CFG_OFS) >> 2);
  assign mapped  = cfg_hit || PADDR_I == ricd_pkg::CTRL_OFS || PADDR_I == ricd_pkg::STATUS_OFS
                   || PADDR_I == ricd_pkg::LEVEL_OFS || PADDR_I == ricd_pkg::STATE_OFS;
  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = PSEL_I & PENABLE_I & ~mapped;
  assign POWER_STEP_W_O = ricd_pkg::POWER_STEP_W;

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (cfg_hit) begin
      next_rdata[ricd_pkg::CFG_CHAN_LSB +: 3]   = edit_cfg[cfg_idx].chan;
      next_rdata[ricd_pkg::CFG_MODE_LSB +: 4]   = edit_cfg[cfg_idx].mode;
      next_rdata[ricd_pkg::CFG_PRESET_LSB +: 4] = edit_cfg[cfg_idx].preset;
      next_rdata[ricd_pkg::CFG_EXEMPT_BIT]      = edit_cfg[cfg_idx].exempt;
    end else if (PADDR_I == ricd_pkg::STATUS_OFS) begin
      next_rdata[0] = LOCAL_REMOTE_SEL_I;
    end else if (PADDR_I == ricd_pkg::LEVEL_OFS) begin
      next_rdata[N-1:0] = sync_b;
    end else if (PADDR_I == ricd_pkg::STATE_OFS) begin
      next_rdata[ricd_pkg::STATE_RF_BIT]          = state.rf_on;
      next_rdata[ricd_pkg::STATE_EXC_B_BIT]       = state.exciter_b;
      next_rdata[ricd_pkg::STATE_AUTO_BIT]        = state.auto_co;
      next_rdata[ricd_pkg::STATE_PRESET_LSB +: 4] = state.preset;
    end
  end

  // read data captured in the setup cycle, valid in the access cycle
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      PRDATA_O <= 32'h0000_0000;
    end else if (acc_rd) begin
      PRDATA_O <= next_rdata;
    end
  end

  // edit copy and committed copy of the configuration
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      for (int i = 0; i < N; i++) begin
        // index folded into the table range so unrolled copies stay in bounds
        edit_cfg[i] <= (i < ricd_pkg::FACTORY_COUNT) ? ricd_pkg::FACTORY_CFG[i % ricd_pkg::FACTORY_COUNT]
                                                     : ricd_pkg::CFG_RESET_VAL;
        act_cfg[i]  <= (i < ricd_pkg::FACTORY_COUNT) ? ricd_pkg::FACTORY_CFG[i % ricd_pkg::FACTORY_COUNT]
                                                     : ricd_pkg::CFG_RESET_VAL;
      end
    end else if (acc_wr && PADDR_I == ricd_pkg::CTRL_OFS) begin
      if (PWDATA_I[ricd_pkg::CTRL_COMMIT_BIT]) begin
        act_cfg <= edit_cfg;
      end else if (PWDATA_I[ricd_pkg::CTRL_DISCARD_BIT]) begin
        edit_cfg <= act_cfg;
      end
    end else if (acc_wr && cfg_hit) begin
      edit_cfg[cfg_idx].chan   <= ricd_pkg::ricd_chan_type'(PWDATA_I[ricd_pkg::CFG_CHAN_LSB +: 3]);
      edit_cfg[cfg_idx].mode   <= ricd_pkg::ricd_mode_type'(PWDATA_I[ricd_pkg::CFG_MODE_LSB +: 4]);
      edit_cfg[cfg_idx].preset <= PWDATA_I[ricd_pkg::CFG_PRESET_LSB +: 4];
      edit_cfg[cfg_idx].exempt <= PWDATA_I[ricd_pkg::CFG_EXEMPT_BIT];
    end
  end

  // per-input trigger decode and power repeat timer
  for (genvar g = 0; g < N; g++) begin : g_in
    logic          en;
    logic [CW-1:0] rep_cnt;

    // status is never written from here, only the local operator drives it
    assign en = (LOCAL_REMOTE_SEL_I | act_cfg[g].exempt)
                & (act_cfg[g].chan != ricd_pkg::CH_NONE);

    always_comb begin
      ev_on[g]  = 1'b0;
      ev_off[g] = 1'b0;
      ev_tog[g] = 1'b0;
      hold[g]   = 1'b0;
      is_dec[g] = 1'b0;
      case (act_cfg[g].mode)
        ricd_pkg::MD_FALL_ON:          ev_on[g]  = fall[g];
        ricd_pkg::MD_RISE_ON:          ev_on[g]  = rise[g];
        ricd_pkg::MD_FALL_OFF:         ev_off[g] = fall[g];
        ricd_pkg::MD_RISE_OFF:         ev_off[g] = rise[g];
        ricd_pkg::MD_FALL_TOG:         ev_tog[g] = fall[g];
        ricd_pkg::MD_RISE_TOG:         ev_tog[g] = rise[g];
        ricd_pkg::MD_RISE_ON_FALL_OFF: begin
          ev_on[g]  = rise[g];
          ev_off[g] = fall[g];
        end
        ricd_pkg::MD_FALL_ON_RISE_OFF: begin
          ev_on[g]  = fall[g];
          ev_off[g] = rise[g];
        end
        ricd_pkg::MD_HIGH_INC, ricd_pkg::MD_HIGH_ON: begin
          ev_on[g] = rise[g];
          hold[g]  = sync_b[g];
        end
        ricd_pkg::MD_LOW_INC, ricd_pkg::MD_LOW_ON: begin
          ev_on[g] = fall[g];
          hold[g]  = ~sync_b[g];
        end
        ricd_pkg::MD_HIGH_DEC: begin
          ev_on[g]  = rise[g];
          hold[g]   = sync_b[g];
          is_dec[g] = 1'b1;
        end
        ricd_pkg::MD_LOW_DEC: begin
          ev_on[g]  = fall[g];
          hold[g]   = ~sync_b[g];
          is_dec[g] = 1'b1;
        end
        default: ;
      endcase
      if (!en) begin
        ev_on[g]  = 1'b0;
        ev_off[g] = 1'b0;
        ev_tog[g] = 1'b0;
        hold[g]   = 1'b0;
      end
    end

    // first step on activation, then one per repeat period while held
    always_ff @(posedge CORE_CLK_I) begin
      if (SYS_RST_I) begin
        rep_cnt <= '0;
      end else if (ev_on[g] || !hold[g] || act_cfg[g].chan != ricd_pkg::CH_POWER) begin
        rep_cnt <= '0;
      end else if (rep_cnt == CW'(REPEAT_CYCLES - 1)) begin
        rep_cnt <= '0;
      end else begin
        rep_cnt <= rep_cnt + 1'b1;
      end
    end

    assign rep_step[g] = hold[g] && act_cfg[g].chan == ricd_pkg::CH_POWER
                         && !ev_on[g] && rep_cnt == CW'(REPEAT_CYCLES - 1);
  end

  // gather events per channel; lowest numbered preset input wins
  always_comb begin
    any_rf_on    = 1'b0;
    any_rf_off   = 1'b0;
    any_rf_tog   = 1'b0;
    any_reset    = 1'b0;
    any_up       = 1'b0;
    any_down     = 1'b0;
    any_exc_a    = 1'b0;
    any_exc_b    = 1'b0;
    any_exc_tog  = 1'b0;
    any_auto_tog = 1'b0;
    any_wdog     = 1'b0;
    any_preset   = 1'b0;
    next_preset  = state.preset;
    for (int i = N - 1; i >= 0; i--) begin
      case (act_cfg[i].chan)
        ricd_pkg::CH_RF: begin
          any_rf_on  = any_rf_on | ev_on[i];
          any_rf_off = any_rf_off | ev_off[i];
          any_rf_tog = any_rf_tog | ev_tog[i];
        end
        ricd_pkg::CH_RESET: begin
          any_reset = any_reset | ev_on[i] | ev_tog[i];
        end
        ricd_pkg::CH_POWER: begin
          any_up   = any_up | ((ev_on[i] | rep_step[i]) & ~is_dec[i]);
          any_down = any_down | ((ev_on[i] | rep_step[i]) & is_dec[i]) | ev_off[i];
        end
        ricd_pkg::CH_EXCITER: begin
          any_exc_b   = any_exc_b | ev_on[i];
          any_exc_a   = any_exc_a | ev_off[i];
          any_exc_tog = any_exc_tog | ev_tog[i];
        end
        ricd_pkg::CH_AUTO_CO: begin
          any_auto_tog = any_auto_tog | ev_on[i] | ev_tog[i];
        end
        ricd_pkg::CH_WATCHDOG: begin
          any_wdog = any_wdog | ev_on[i] | ev_tog[i];
        end
        ricd_pkg::CH_PRESET: begin
          if (ev_on[i] || ev_tog[i]) begin
            any_preset  = 1'b1;
            next_preset = act_cfg[i].preset;
          end
        end
        default: ;
      endcase
    end
  end

  // transmitter state held by this block
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      state <= ricd_pkg::STATE_RESET_VAL;
    end else begin
      if (any_rf_off) begin
        state.rf_on <= 1'b0;  // off wins over on
      end else if (any_rf_on) begin
        state.rf_on <= 1'b1;
      end else if (any_rf_tog) begin
        state.rf_on <= ~state.rf_on;
      end
      if (any_exc_a) begin
        state.exciter_b <= 1'b0;
      end else if (any_exc_b) begin
        state.exciter_b <= 1'b1;
      end else if (any_exc_tog) begin
        state.exciter_b <= ~state.exciter_b;
      end
      if (any_auto_tog) begin
        state.auto_co <= ~state.auto_co;
      end
      if (any_preset) begin
        state.preset <= next_preset;
      end
    end
  end

  // registered command pulses
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      RF_ON_REQ_O     <= 1'b0;
      RF_OFF_REQ_O    <= 1'b0;
      SYS_RESET_REQ_O <= 1'b0;
      POWER_UP_O      <= 1'b0;
      POWER_DOWN_O    <= 1'b0;
      WDOG_RST_O      <= 1'b0;
      PRESET_LOAD_O   <= 1'b0;
    end else begin
      RF_ON_REQ_O     <= ~any_rf_off & (any_rf_on | (any_rf_tog & ~state.rf_on));
      RF_OFF_REQ_O    <= any_rf_off | (~any_rf_on & any_rf_tog & state.rf_on);
      SYS_RESET_REQ_O <= any_reset;
      POWER_UP_O      <= any_up & ~any_down;
      POWER_DOWN_O    <= any_down & ~any_up;
      WDOG_RST_O      <= any_wdog;
      PRESET_LOAD_O   <= any_preset;
    end
  end

  assign EXCITER_B_O  = state.exciter_b;
  assign AUTO_CO_EN_O = state.auto_co;
  assign PRESET_SEL_O = state.preset;

endmodule // ricd_top

`default_nettype wire

// File: ricd_chk.sv
// assertions on the remote input command decoder ports
// assumes one core clock domain and the synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module ricd_chk (
  input wire logic                            CORE_CLK_I,
  input wire logic                            SYS_RST_I,
  input wire logic [ricd_pkg::NUM_INPUTS-1:0] REMOTE_IN_I,
  input wire logic                            LOCAL_REMOTE_SEL_I,
  input wire logic                            PSEL_I,
  input wire logic                            PENABLE_I,
  input wire logic                            PREADY_O,
  input wire logic                            PSLVERR_O,
  input wire logic                            RF_ON_REQ_O,
  input wire logic                            RF_OFF_REQ_O,
  input wire logic                            SYS_RESET_REQ_O,
  input wire logic                            POWER_UP_O,
  input wire logic                            POWER_DOWN_O,
  input wire logic [15:0]                     POWER_STEP_W_O,
  input wire logic                            EXCITER_B_O,
  input wire logic                            AUTO_CO_EN_O,
  input wire logic                            WDOG_RST_O,
  input wire logic                            PRESET_LOAD_O
);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (SYS_RST_I);

  logic [2:0] lo_cnt;
  wire        cmd = RF_ON_REQ_O | RF_OFF_REQ_O | SYS_RESET_REQ_O | WDOG_RST_O | PRESET_LOAD_O;

  // cycles spent in local operation, saturating
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I || LOCAL_REMOTE_SEL_I) lo_cnt <= 3'h0;
    else if (lo_cnt != 3'h7) lo_cnt <= lo_cnt + 3'h1;
  end

  // an input moved three cycles before the answer
  sequence s_in_moved;
    $past(REMOTE_IN_I, 3) != $past(REMOTE_IN_I, 4);
  endsequence

  a_step_const: assert property (POWER_STEP_W_O == 16'h0064) else $error("step size wrong");
  a_ready_high: assert property (PREADY_O) else $error("ready low");
  a_err_access: assert property (PSLVERR_O |-> PSEL_I && PENABLE_I) else $error("error outside access");
  a_rf_exclusive: assert property (!(RF_ON_REQ_O && RF_OFF_REQ_O)) else $error("rf on and off together");
  a_step_exclusive: assert property (!(POWER_UP_O && POWER_DOWN_O)) else $error("up and down together");
  a_cmd_cause: assert property (cmd |-> s_in_moved) else $error("command without input change");
  a_exc_cause: assert property ($changed(EXCITER_B_O) |-> s_in_moved) else $error("exciter moved alone");
  a_auto_cause: assert property ($changed(AUTO_CO_EN_O) |-> s_in_moved) else $error("changeover moved alone");
  a_rf_single: assert property (RF_ON_REQ_O |=> !RF_ON_REQ_O) else $error("rf request too long");
  a_remote_gate: assert property (lo_cnt == 3'h7 |-> !(cmd || POWER_UP_O || POWER_DOWN_O)
    && $stable(EXCITER_B_O) && $stable(AUTO_CO_EN_O)) else $error("command in local");
endmodule // ricd_chk

bind ricd_top ricd_chk i_ricd_chk (.CORE_CLK_I(CORE_CLK_I), .SYS_RST_I(SYS_RST_I), .REMOTE_IN_I(REMOTE_IN_I),
  .LOCAL_REMOTE_SEL_I(LOCAL_REMOTE_SEL_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PREADY_O(PREADY_O),
  .PSLVERR_O(PSLVERR_O), .RF_ON_REQ_O(RF_ON_REQ_O), .RF_OFF_REQ_O(RF_OFF_REQ_O), .SYS_RESET_REQ_O(SYS_RESET_REQ_O),
  .POWER_UP_O(POWER_UP_O), .POWER_DOWN_O(POWER_DOWN_O), .POWER_STEP_W_O(POWER_STEP_W_O),
  .EXCITER_B_O(EXCITER_B_O), .AUTO_CO_EN_O(AUTO_CO_EN_O), .WDOG_RST_O(WDOG_RST_O), .PRESET_LOAD_O(PRESET_LOAD_O));
`default_nettype wire

// File: ricd_remote_unit.sv
// remote control unit model driving the 24 parallel input lines
// assumes lines idle high through pull-ups; levels change after a rising edge
`timescale 1ns/1ps
`default_nettype none
module ricd_remote_unit (
  input  wire logic        clk_i,
  output logic      [23:0] lines_o
);
  initial lines_o = 24'hFFFFFF;

  task automatic drive(input int idx, input logic lvl, input int hold);
    @(posedge clk_i);
    lines_o[idx] <= lvl;
    repeat (hold < 6 ? 6 : hold) @(posedge clk_i);
  endtask
endmodule // ricd_remote_unit
`default_nettype wire

// File: tb.sv
// self-checking bench for the remote input command decoder
// assumes the remote unit model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int REP = 20;
  logic        clk, rst, loc, psel, pen, pwr, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        rf_on, rf_off, sys_rst, p_up, p_dn, exc_b, auto_co, wdog, p_load;
  logic [15:0] step_w;
  logic [3:0]  p_sel;
  logic [23:0] lines;
  int          num_errors, num_checks, n_on, n_off, n_up, n_dn, n_rst, n_wd, n_pl;

  ricd_remote_unit rm (.clk_i(clk), .lines_o(lines));
  ricd_top #(.REPEAT_CYCLES(REP)) i_ricd_top (.CORE_CLK_I(clk), .SYS_RST_I(rst), .REMOTE_IN_I(lines),
    .LOCAL_REMOTE_SEL_I(loc), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .RF_ON_REQ_O(rf_on),
    .RF_OFF_REQ_O(rf_off), .SYS_RESET_REQ_O(sys_rst), .POWER_UP_O(p_up), .POWER_DOWN_O(p_dn),
    .POWER_STEP_W_O(step_w), .EXCITER_B_O(exc_b), .AUTO_CO_EN_O(auto_co), .WDOG_RST_O(wdog),
    .PRESET_LOAD_O(p_load), .PRESET_SEL_O(p_sel));

  always @(posedge clk) begin
    n_on += (rf_on === 1'b1); n_off += (rf_off === 1'b1); n_up += (p_up === 1'b1); n_dn += (p_dn === 1'b1);
    n_rst += (sys_rst === 1'b1); n_wd += (wdog === 1'b1); n_pl += (p_load === 1'b1);
  end

  task automatic clr;
    n_on = 0; n_off = 0; n_up = 0; n_dn = 0; n_rst = 0; n_wd = 0; n_pl = 0;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1; pen <= 1'b0; pwr <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      num_errors++;
      results;
    end
    q = prdata; e = pslverr;
    psel <= 1'b0; pen <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    check(q, exp);
    check({31'h0, e}, {31'h0, experr});
  endtask

  task automatic t_regs;
    logic [31:0] f [8] = '{32'h001, 32'h021, 32'h093, 32'h0D3, 32'h024, 32'h004, 32'h045, 32'h000};
    for (int i = 0; i < 8; i++) rdchk(ricd_pkg::CFG_OFS + 12'(4 * i), f[i], 1'b0);
    rdchk(ricd_pkg::LEVEL_OFS, 32'h00FFFFFF, 1'b0);
    rdchk(ricd_pkg::STATUS_OFS, 32'h1, 1'b0);
    rdchk(12'h7F0, 32'h0, 1'b1);
    $display("t_regs done");
  endtask

  task automatic t_rf;
    clr;
    rm.drive(0, 1'b0, 6);
    rdchk(ricd_pkg::LEVEL_OFS, 32'h00FFFFFE, 1'b0);
    rm.drive(0, 1'b1, 6); rm.drive(1, 1'b0, 6); rm.drive(1, 1'b1, 6);
    check(n_on, 1);
    check(n_off, 1);
    loc <= 1'b0;
    clr;
    rm.drive(0, 1'b0, 6); rm.drive(0, 1'b1, 6);
    check(n_on, 0);
    rdchk(ricd_pkg::STATUS_OFS, 32'h0, 1'b0);
    loc <= 1'b1;
    $display("t_rf done");
  endtask

  task automatic t_power;
    clr;
    rm.drive(2, 1'b0, 2 * REP + 5); rm.drive(2, 1'b1, 6);
    check(n_up, 3);
    rm.drive(3, 1'b0, 6); rm.drive(3, 1'b1, 6);
    check(n_dn, 1);
    check({16'h0, step_w}, 32'h64);
    $display("t_power done");
  endtask

  task automatic t_exc;
    rm.drive(5, 1'b0, 6);
    check(exc_b, 1'b1);
    rm.drive(5, 1'b1, 6); rm.drive(4, 1'b0, 6);
    check(exc_b, 1'b0);
    rm.drive(4, 1'b1, 6); rm.drive(6, 1'b0, 6);
    check(auto_co, 1'b1);
    rm.drive(6, 1'b1, 6); rm.drive(6, 1'b0, 6);
    check(auto_co, 1'b0);
    rm.drive(6, 1'b1, 6);
    $display("t_exc done");
  endtask

  task automatic t_cfg;
    wr(ricd_pkg::CFG_OFS + 12'h01C, 32'h016);
    wr(ricd_pkg::CFG_OFS + 12'h020, 32'h062);
    wr(ricd_pkg::CFG_OFS + 12'h024, 32'h5B7);
    clr;
    rm.drive(7, 1'b0, 6); rm.drive(7, 1'b1, 6);
    check(n_wd, 0);
    wr(ricd_pkg::CTRL_OFS, 32'h1);
    rm.drive(7, 1'b0, 6); rm.drive(7, 1'b1, 6);
    check(n_wd, 1);
    rm.drive(8, 1'b0, 6); rm.drive(8, 1'b1, 6); rm.drive(8, 1'b0, 6);
    check(n_rst, 1);
    rm.drive(9, 1'b0, 6);
    check(n_pl, 1);
    check(p_sel, 4'h5);
    rdchk(ricd_pkg::STATE_OFS, 32'h50, 1'b0);
    rm.drive(9, 1'b1, 6);
    clr;
    rm.drive(10, 1'b0, 6); rm.drive(10, 1'b1, 6);
    check(n_on + n_off + n_up + n_dn + n_rst + n_wd + n_pl, 0);
    wr(ricd_pkg::CFG_OFS + 12'h02C, 32'h001);
    wr(ricd_pkg::CTRL_OFS, 32'h2);
    rdchk(ricd_pkg::CFG_OFS + 12'h02C, 32'h0, 1'b0);
    wr(ricd_pkg::CFG_OFS + 12'h030, 32'h051);
    wr(ricd_pkg::CTRL_OFS, 32'h1);
    clr;
    rm.drive(12, 1'b0, 6); rm.drive(12, 1'b1, 6); rm.drive(12, 1'b0, 6); rm.drive(12, 1'b1, 6);
    check(n_on, 1);
    check(n_off, 1);
    $display("t_cfg done");
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    results;
  end

  initial begin
    rst = 1'b1; loc = 1'b1; psel = 1'b0; pen = 1'b0; pwr = 1'b0; paddr = 12'h0; pwdata = 32'h0;
    num_errors = 0; num_checks = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    t_regs;
    t_rf;
    t_power;
    t_exc;
    t_cfg;
    results;
  end
endmodule // tb
`default_nettype wire
